/* File: include/i2cmr_pkg.sv */
/*
 * Constants for the two-wire master receive engine.
 * Assumes a 40 MHz system clock and synchronous pin inputs.
 */
package i2cmr_pkg;
    // ==========================================================
    // Control field positions
    localparam int          RCV_EN_BIT   = 3;      // Receive enable in control two
    localparam int          ACK_EN_BIT   = 4;      // Acknowledge sequence enable
    localparam logic [3:0]  MODE_MASTER  = 4'h8;   // Master mode select code
    localparam int          RELOAD_W     = 7;      // Reload field width
    localparam int          BITS_PER_BYTE = 8;     // Data bits per byte
    localparam logic [3:0]  LAST_EDGE    = 4'hF;   // Falling edge of eighth clock
    localparam logic [7:0]  BYTE_RST     = 8'h00;  // Data reset value
    localparam logic [6:0]  CNT_RST      = 7'h00;  // Counter reset value
    localparam logic [3:0]  EDGE_RST     = 4'h0;   // Edge counter reset value
    localparam int          FIFO_DEPTH   = 8;      // Receive FIFO depth
    localparam int          FIFO_WIDTH   = 8;      // Receive FIFO width
    // ==========================================================
    // Engine states
    typedef enum logic [1:0] {I2CMR_IDLE, I2CMR_RECV, I2CMR_ACK} i2cmr_state_t;
endpackage : i2cmr_pkg

/* File: core/i2cmr_fifo.sv */
/*
 * Parameterised FIFO for received bytes.
 * Assumes one clock, synchronous active-high reset, clock enable.
 */
`timescale 1ns/10ps
module i2cmr_fifo
    import i2cmr_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             clkEn,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    // ==========================================================
    // Storage and pointers
    logic [WIDTH-1:0] mem [DEPTH];          // Word storage
    logic [AW-1:0]    wrPtr_reg, wrPtr_next; // Write pointer
    logic [AW-1:0]    rdPtr_reg, rdPtr_next; // Read pointer
    logic [AW:0]      cnt_reg, cnt_next;     // Fill count
    logic             push;                  // Word accepted
    logic             pop;                   // Word drained

    // Handshakes
    always_comb begin
        inReady  = (cnt_reg != (AW+1)'(DEPTH)) && clkEn;
        outValid = (cnt_reg != '0);
        outData  = mem[rdPtr_reg];
        push     = inValid && inReady;
        pop      = outValid && outReady && clkEn;
        wrPtr_next = push ? AW'(wrPtr_reg + 1'b1) : wrPtr_reg;
        rdPtr_next = pop ? AW'(rdPtr_reg + 1'b1) : rdPtr_reg;
        cnt_next   = (AW+1)'(cnt_reg + push - pop);
    end

    // Register pointers and storage
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            cnt_reg   <= '0;
        end else if (clkEn) begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            cnt_reg   <= cnt_next;
            if (push) begin
                mem[wrPtr_reg] <= inData;
            end
        end
    end
endmodule : i2cmr_fifo

/* File: core/i2cmr_core.sv */
/*
 * Two-wire bus master byte receiver with buffer and status flags.
 * Assumes pins sampled synchronously, open-drain resolved outside.
 */
// Functional notes
// - Receive starts when receive enable bit set
// - Receive enable ignored unless port idle
// - Toggle clock each rollover, shift data in
// - After eighth fall: clear enable, buffer, flags
// - Return idle after byte transfer
// - Reading buffer clears buffer full flag
// - Acknowledge enable sends acknowledge bit
// - Overflow when byte arrives while buffer full
// - Buffer write during shifting sets collision, discarded
// - Low seven address bits reload the generator
// - Code 1000 selects master, clock divides
// - Port enable hands pins to port
`timescale 1ns/10ps
module i2cmr_core
    import i2cmr_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       clkEn,
    input  wire logic       serialPortEnable,
    input  wire logic [3:0] serialModeSelect,
    input  wire logic [6:0] addressReload,
    input  wire logic [7:0] ctrlTwoWrData,
    input  wire logic       ctrlTwoWr,
    output logic      [7:0] serialControlTwo,
    input  wire logic       bufRd,
    input  wire logic       bufWr,
    input  wire logic [7:0] bufWrData,
    output logic      [7:0] serialBuffer,
    output logic            bufferFullFlag,
    output logic            serialInterruptFlag,
    input  wire logic       intClr,
    output logic            receiveOverflowFlag,
    input  wire logic       ovfClr,
    output logic            writeCollisionFlag,
    input  wire logic       wcolClr,
    input  wire logic       ackData,
    input  wire logic       sclIn,
    output logic            sclOut,
    output logic            sclOe,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    output logic            gpioMode,
    output logic      [7:0] fifoData,
    output logic            fifoValid,
    input  wire logic       fifoReady
);
    // ==========================================================
    // State
    i2cmr_state_t state_reg, state_next;    // Engine state
    logic [6:0] brg_reg, brg_next;          // Baud counter
    logic [3:0] edge_reg, edge_next;        // Clock edge count
    logic       scl_reg, scl_next;          // Driven clock level
    logic [7:0] shift_reg, shift_next;      // Serial shift register
    logic [7:0] buf_reg, buf_next;          // Receive buffer
    logic       bf_reg, bf_next;            // Buffer full
    logic       if_reg, if_next;            // Interrupt flag
    logic       ov_reg, ov_next;            // Overflow
    logic       wc_reg, wc_next;            // Write collision
    logic       receive_enable_bit_reg, receive_enable_bit_next;        // Receive enable bit
    logic       acknowledge_sequence_enable_reg, acknowledge_sequence_enable_next;      // Acknowledge enable bit
    logic       ackDat_reg, ackDat_next;    // Acknowledge level
    logic [7:0] ctl_reg, ctl_next;          // Other control bits
    logic       fifoInReady;                // FIFO can accept
    logic       fifoPush;                   // Push received byte
    logic       rollover;                   // Generator rolled
    logic       masterOn;                   // Master mode active

    // ==========================================================
    // Receive FIFO
    i2cmr_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .inData   (shift_next),
        .inValid  (fifoPush),
        .inReady  (fifoInReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (fifoReady)
    );

    // Next-state logic
    always_comb begin
        masterOn     = serialPortEnable && (serialModeSelect == MODE_MASTER);
        rollover     = (brg_reg == CNT_RST);
        state_next   = state_reg;
        brg_next     = brg_reg;
        edge_next    = edge_reg;
        scl_next     = scl_reg;
        shift_next   = shift_reg;
        buf_next     = buf_reg;
        bf_next      = bf_reg;
        if_next      = if_reg && !intClr;
        ov_next      = ov_reg && !ovfClr;
        wc_next      = wc_reg && !wcolClr;
        receive_enable_bit_next    = receive_enable_bit_reg;
        acknowledge_sequence_enable_next   = acknowledge_sequence_enable_reg;
        ackDat_next  = ackDat_reg;
        ctl_next     = ctl_reg;
        fifoPush     = 1'b0;
        // Read of buffer clears full; set below wins
        if (bufRd) begin
            bf_next = 1'b0;
        end
        // Control two write
        if (ctrlTwoWr) begin
            ctl_next = ctrlTwoWrData;
            if (state_reg == I2CMR_IDLE && masterOn) begin
                receive_enable_bit_next  = ctrlTwoWrData[RCV_EN_BIT];
                acknowledge_sequence_enable_next = ctrlTwoWrData[ACK_EN_BIT] && !ctrlTwoWrData[RCV_EN_BIT];
                ackDat_next = ackData;
            end
        end
        // Buffer write; a receive counts as begun once enable is latched
        if (bufWr) begin
            if (state_reg == I2CMR_RECV || receive_enable_bit_reg) begin
                wc_next = 1'b1;
            end else begin
                buf_next = bufWrData;
            end
        end
        case (state_reg)
            I2CMR_IDLE: begin
                brg_next  = addressReload;
                edge_next = EDGE_RST;
                if (receive_enable_bit_reg && masterOn) begin
                    state_next = I2CMR_RECV;
                end else if (acknowledge_sequence_enable_reg && masterOn) begin
                    state_next = I2CMR_ACK;
                end
            end
            I2CMR_RECV: begin
                if (!masterOn) begin
                    state_next = I2CMR_IDLE;
                    receive_enable_bit_next  = 1'b0;
                    scl_next   = 1'b0;
                end else if (!rollover) begin
                    brg_next = brg_reg - 7'h01;
                end else begin
                    brg_next  = addressReload;
                    scl_next  = !scl_reg;
                    edge_next = edge_reg + 4'h1;
                    if (!scl_reg) begin
                        shift_next = {shift_reg[BITS_PER_BYTE-2:0], sdaIn};
                    end
                    if (edge_reg == LAST_EDGE) begin
                        receive_enable_bit_next  = 1'b0;
                        buf_next   = shift_reg;
                        bf_next    = 1'b1;
                        if_next    = 1'b1;
                        scl_next   = 1'b0;
                        fifoPush   = fifoInReady;
                        ov_next    = ov_next || bf_reg;
                        state_next = I2CMR_IDLE;
                    end
                end
            end
            I2CMR_ACK: begin
                if (!rollover) begin
                    brg_next = brg_reg - 7'h01;
                end else begin
                    brg_next  = addressReload;
                    scl_next  = !scl_reg;
                    edge_next = edge_reg + 4'h1;
                    if (edge_reg[0]) begin
                        acknowledge_sequence_enable_next = 1'b0;
                        if_next    = 1'b1;
                        state_next = I2CMR_IDLE;
                    end
                end
            end
            default: state_next = I2CMR_IDLE;
        endcase
        // Hold off the final edge while the FIFO is full
        if (state_reg == I2CMR_RECV && rollover && edge_reg == LAST_EDGE && !fifoInReady) begin
            state_next = state_reg;
            brg_next   = brg_reg;
            edge_next  = edge_reg;
            scl_next   = scl_reg;
            shift_next = shift_reg;
            buf_next   = buf_reg;
            bf_next    = bf_reg && !bufRd;
            if_next    = if_reg && !intClr;
            ov_next    = ov_reg && !ovfClr;
            receive_enable_bit_next  = receive_enable_bit_reg;
        end
    end

    // Register all state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg  <= I2CMR_IDLE;
            brg_reg    <= CNT_RST;
            edge_reg   <= EDGE_RST;
            scl_reg    <= 1'b0;
            shift_reg  <= BYTE_RST;
            buf_reg    <= BYTE_RST;
            bf_reg     <= 1'b0;
            if_reg     <= 1'b0;
            ov_reg     <= 1'b0;
            wc_reg     <= 1'b0;
            receive_enable_bit_reg   <= 1'b0;
            acknowledge_sequence_enable_reg  <= 1'b0;
            ackDat_reg <= 1'b0;
            ctl_reg    <= BYTE_RST;
        end else if (clkEn) begin
            state_reg  <= state_next;
            brg_reg    <= brg_next;
            edge_reg   <= edge_next;
            scl_reg    <= scl_next;
            shift_reg  <= shift_next;
            buf_reg    <= buf_next;
            bf_reg     <= bf_next;
            if_reg     <= if_next;
            ov_reg     <= ov_next;
            wc_reg     <= wc_next;
            receive_enable_bit_reg   <= receive_enable_bit_next;
            acknowledge_sequence_enable_reg  <= acknowledge_sequence_enable_next;
            ackDat_reg <= ackDat_next;
            ctl_reg    <= ctl_next;
        end
    end

    // Outputs: open-drain, low pulled while enable high
    always_comb begin
        serialControlTwo = ctl_reg;
        serialControlTwo[RCV_EN_BIT] = receive_enable_bit_reg;
        serialControlTwo[ACK_EN_BIT] = acknowledge_sequence_enable_reg;
        serialBuffer        = buf_reg;
        bufferFullFlag      = bf_reg;
        serialInterruptFlag = if_reg;
        receiveOverflowFlag = ov_reg;
        writeCollisionFlag  = wc_reg;
        gpioMode = !serialPortEnable;
        sclOut   = 1'b0;
        sdaOut   = 1'b0;
        sclOe    = serialPortEnable && !scl_reg;
        sdaOe    = serialPortEnable && (state_reg == I2CMR_ACK) && !ackDat_reg;
    end
endmodule : i2cmr_core

/* File: dv/i2cmr_props.sv */
/*
 * Port checker for the two-wire master receive engine.
 * Assumes one clock, synchronous high reset; checks pause while frozen.
 */
`timescale 1ns/10ps
module i2cmr_props
    import i2cmr_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       clkEn,
    input wire logic       serialPortEnable,
    input wire logic [3:0] serialModeSelect,
    input wire logic [6:0] addressReload,
    input wire logic [7:0] ctrlTwoWrData,
    input wire logic       ctrlTwoWr,
    input wire logic [7:0] serialControlTwo,
    input wire logic       bufRd,
    input wire logic       bufWr,
    input wire logic [7:0] serialBuffer,
    input wire logic       bufferFullFlag,
    input wire logic       serialInterruptFlag,
    input wire logic       receiveOverflowFlag,
    input wire logic       writeCollisionFlag,
    input wire logic       sclOe,
    input wire logic       gpioMode
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst || !clkEn);
    // ==========================================================
    // Clock toggle spacing and count
    logic       sclPrev_reg;                          // Last clock drive
    logic       rcvPrev_reg;                          // Last receive enable
    logic [7:0] gap_reg;                              // Cycles since toggle
    logic [4:0] togs_reg;                             // Toggles this byte
    wire        rcv = serialControlTwo[RCV_EN_BIT];
    wire        tog = sclOe != sclPrev_reg;
    always_ff @(posedge sys_clk) begin
        sclPrev_reg <= sclOe;
        rcvPrev_reg <= rst ? 1'b0 : rcv;
        gap_reg     <= (rst || tog) ? 8'(clkEn && !rst) : gap_reg + 8'(clkEn);
        togs_reg    <= (rcv || rcvPrev_reg) ? togs_reg + 5'(tog) : 5'h00;
    end
    // ==========================================================
    // Properties
    sequence s_start;
        ctrlTwoWr && ctrlTwoWrData[RCV_EN_BIT] && !rcv && !serialControlTwo[ACK_EN_BIT]
            && serialPortEnable && serialModeSelect == MODE_MASTER;
    endsequence
    sequence s_done;
        rcv ##1 !rcv;
    endsequence
    property p_start; s_start |=> rcv; endproperty
    property p_refuse; ctrlTwoWr && !rcv && serialModeSelect != MODE_MASTER |=> !rcv; endproperty
    property p_period;
        tog && rcv && togs_reg != 5'h00 |-> gap_reg == {1'b0, addressReload} + 8'h01;
    endproperty
    property p_count; s_done |=> togs_reg == 5'd16; endproperty
    property p_done; s_done |-> ##[0:1] (bufferFullFlag && serialInterruptFlag && sclOe);
    endproperty
    property p_ovf; bufferFullFlag && rcv ##1 !rcv |-> ##[0:1] receiveOverflowFlag; endproperty
    property p_read; bufRd && !rcv |=> !bufferFullFlag; endproperty
    property p_write_collision_flag; bufWr && rcv ##1 rcv |-> writeCollisionFlag && $stable(serialBuffer);
    endproperty
    property p_gpio;
        gpioMode != serialPortEnable && (serialPortEnable || !sclOe);
    endproperty
    a_start: assert property (p_start) else $error("receive did not start");
    a_refuse: assert property (p_refuse) else $error("receive started off mode");
    a_period: assert property (p_period) else $error("clock toggle spacing wrong");
    a_count: assert property (p_count) else $error("clock toggle count wrong");
    a_done: assert property (p_done) else $error("completion flags missing");
    a_ovf: assert property (p_ovf) else $error("overflow not flagged");
    a_read: assert property (p_read) else $error("read left buffer full");
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not handled");
    a_gpio: assert property (p_gpio) else $error("pin ownership wrong");
endmodule : i2cmr_props

bind i2cmr_core i2cmr_props chk (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
    .serialPortEnable(serialPortEnable), .serialModeSelect(serialModeSelect),
    .addressReload(addressReload), .ctrlTwoWrData(ctrlTwoWrData), .ctrlTwoWr(ctrlTwoWr),
    .serialControlTwo(serialControlTwo), .bufRd(bufRd), .bufWr(bufWr),
    .serialBuffer(serialBuffer), .bufferFullFlag(bufferFullFlag),
    .serialInterruptFlag(serialInterruptFlag), .receiveOverflowFlag(receiveOverflowFlag),
    .writeCollisionFlag(writeCollisionFlag), .sclOe(sclOe), .gpioMode(gpioMode));

/* File: dv/i2cmr_slave_model.sv */
/*
 * Slave model that sends one byte per load.
 * Assumes pulled-up lines; sdaPull high pulls data low.
 */
`timescale 1ns/10ps
module i2cmr_slave_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       sclLine,
    input  wire logic       load,
    input  wire logic [7:0] txByte,
    output logic            sdaPull
);
    logic [7:0] shift_reg;                            // Bits still to send
    logic [3:0] bitCnt_reg;                           // Bits sent
    logic       sclPrev_reg;                          // Last clock level
    // Next bit after each clock fall, released after the byte
    always_ff @(posedge sys_clk) begin
        sclPrev_reg <= sclLine;
        if (rst) begin
            bitCnt_reg <= 4'h8;
        end else if (load) begin
            shift_reg  <= txByte;
            bitCnt_reg <= 4'h0;
        end else if (sclPrev_reg && !sclLine && bitCnt_reg < 4'h8) begin
            shift_reg  <= shift_reg << 1;
            bitCnt_reg <= bitCnt_reg + 4'h1;
        end
    end
    assign sdaPull = bitCnt_reg < 4'h8 && !shift_reg[7];
endmodule : i2cmr_slave_model

/* File: dv/i2c_master_receive_test.sv */
/*
 * Self-checking bench for the receive engine.
 * Assumes the core, its checker and the slave model.
 */
`timescale 1ns/10ps
module i2c_master_receive_test
    import i2cmr_pkg::*;
;
    logic       sys_clk, rst, clkEn, serialPortEnable, ctrlTwoWr, bufRd, bufWr, ackData;
    logic       intClr, ovfClr, wcolClr, fifoReady, slvLoad, slvPull, sclOut, sdaOut;
    logic       bufferFullFlag, serialInterruptFlag, receiveOverflowFlag, writeCollisionFlag;
    logic       sclOe, sdaOe, gpioMode, fifoValid;
    logic [3:0] serialModeSelect;
    logic [6:0] addressReload;
    logic [7:0] ctrlTwoWrData, bufWrData, slvByte, serialControlTwo, serialBuffer, fifoData, b;
    logic [7:0] p;                                    // Byte held before a collision
    logic [7:0] expQ[$];                              // Expected stream bytes
    int         fails, n_tests, i, n;
    wire        sclLine = sclOe ? sclOut : 1'b1;      // Pulled-up clock
    wire        sdaLine = (sdaOe ? sdaOut : 1'b1) && !slvPull; // Pulled-up data
    i2cmr_core uut (
        .sys_clk             (sys_clk),
        .rst                 (rst),
        .clkEn               (clkEn),
        .serialPortEnable    (serialPortEnable),
        .serialModeSelect    (serialModeSelect),
        .addressReload       (addressReload),
        .ctrlTwoWrData       (ctrlTwoWrData),
        .ctrlTwoWr           (ctrlTwoWr),
        .serialControlTwo    (serialControlTwo),
        .bufRd               (bufRd),
        .bufWr               (bufWr),
        .bufWrData           (bufWrData),
        .serialBuffer        (serialBuffer),
        .bufferFullFlag      (bufferFullFlag),
        .serialInterruptFlag (serialInterruptFlag),
        .intClr              (intClr),
        .receiveOverflowFlag (receiveOverflowFlag),
        .ovfClr              (ovfClr),
        .writeCollisionFlag  (writeCollisionFlag),
        .wcolClr             (wcolClr),
        .ackData             (ackData),
        .sclIn               (sclLine),
        .sclOut              (sclOut),
        .sclOe               (sclOe),
        .sdaIn               (sdaLine),
        .sdaOut              (sdaOut),
        .sdaOe               (sdaOe),
        .gpioMode            (gpioMode),
        .fifoData            (fifoData),
        .fifoValid           (fifoValid),
        .fifoReady           (fifoReady)
    );
    i2cmr_slave_model slv (.sys_clk(sys_clk), .rst(rst), .sclLine(sclLine), .load(slvLoad),
        .txByte(slvByte), .sdaPull(slvPull));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // ==========================================================
    // Helpers
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: byte %h not %h", $time, got, exp);
        end
    endtask : check_byte
    task automatic check_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: flag %b not %b", $time, got, exp);
        end
    endtask : check_bit
    task automatic tick(input int c);
        repeat (c) @(negedge sys_clk);
    endtask : tick
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task automatic ctrl(input logic [7:0] d);
        ctrlTwoWrData = d;
        ctrlTwoWr = 1'b1;
        intClr = 1'b1;
        tick(1);
        ctrlTwoWr = 1'b0;
        intClr = 1'b0;
    endtask : ctrl
    task automatic rx_start(input logic [7:0] d);
        slvByte = d;
        slvLoad = 1'b1;
        addressReload = 7'($urandom_range(3, 1));
        tick(1);
        slvLoad = 1'b0;
        ctrl(8'h08);
        expQ.push_back(d);
    endtask : rx_start
    task automatic rx_end(input logic [7:0] d, input bit rd);
        for (i = 0; i < 3000 && serialControlTwo[RCV_EN_BIT] !== 1'b0; i++) tick(1);
        if (i == 3000) begin
            fails++;
            end_of_test();
        end
        tick(2);
        check_bit(bufferFullFlag, 1'b1);
        check_bit(serialInterruptFlag & sclOe, 1'b1);
        check_byte(serialBuffer, d);
        if (rd) begin
            bufRd = 1'b1;
            tick(1);
            bufRd = 1'b0;
            check_bit(bufferFullFlag, 1'b0);
        end
    endtask : rx_end
    // ==========================================================
    // Stream watcher
    always @(posedge sys_clk) begin
        if (!rst && clkEn === 1'b1 && fifoValid === 1'b1 && fifoReady === 1'b1) begin
            if (expQ.size() == 0) check_bit(1'b1, 1'b0);
            else check_byte(fifoData, expQ.pop_front());
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(21));
        {rst, clkEn, serialPortEnable, ctrlTwoWr, bufRd, bufWr, ackData} = 7'h70;
        {intClr, ovfClr, wcolClr, fifoReady, slvLoad} = 5'h00;
        {ctrlTwoWrData, bufWrData, slvByte, addressReload} = 31'h0;
        serialModeSelect = 4'h7;
        tick(8);
        rst = 1'b0;
        ctrl(8'h08);
        tick(2);
        check_bit(serialControlTwo[RCV_EN_BIT], 1'b0);
        serialModeSelect = MODE_MASTER;
        for (n = 0; n < FIFO_DEPTH; n++) begin
            b = 8'($urandom);
            rx_start(b);
            rx_end(b, 1'b1);
        end
        b = 8'($urandom);
        rx_start(b);
        tick(300);
        check_bit(serialControlTwo[RCV_EN_BIT], 1'b1);
        fifoReady = 1'b1;
        rx_end(b, 1'b1);
        for (n = 0; n < 2; n++) begin
            b = 8'($urandom);
            rx_start(b);
            rx_end(b, n[0]);
        end
        check_bit(receiveOverflowFlag, 1'b1);
        // Freeze mid-byte, then collide a buffer write with the shift
        p = b;
        b = 8'($urandom);
        rx_start(b);
        tick(5);
        clkEn = 1'b0;
        tick(80);
        check_bit(serialControlTwo[RCV_EN_BIT], 1'b1);
        clkEn = 1'b1;
        tick(5);
        {bufWr, bufWrData} = {1'b1, ~p};
        tick(1);
        bufWr = 1'b0;
        check_bit(writeCollisionFlag, 1'b1);
        check_byte(serialBuffer, p);
        rx_end(b, 1'b1);
        ctrl(8'h10);
        tick(1);
        check_bit(sdaOe, 1'b1);
        for (i = 0; i < 500 && serialInterruptFlag !== 1'b1; i++) tick(1);
        if (i == 500) begin
            fails++;
            end_of_test();
        end
        check_bit(serialInterruptFlag, 1'b1);
        // Idle write lands; flag clears take effect
        {bufWr, bufWrData, ovfClr, wcolClr} = {1'b1, ~b, 2'h3};
        tick(1);
        {bufWr, ovfClr, wcolClr} = 3'h0;
        check_byte(serialBuffer, ~b);
        check_bit(receiveOverflowFlag | writeCollisionFlag, 1'b0);
        serialPortEnable = 1'b0;
        tick(3);
        check_bit(gpioMode, 1'b1);
        check_bit(expQ.size() == 0, 1'b1);
        end_of_test();
    end
endmodule : i2c_master_receive_test
